// ### design/pcs_pkg.sv
`default_nettype none
package pcs_pkg;

  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int unsigned PC_W          = 11;
  localparam int unsigned PHASES        = 4;
  // Counter low byte sits at word index 6; the bus decodes byte addresses
  localparam int unsigned IDX_CNT_LOW   = 6;
  localparam logic [11:0] ADDR_CNT_LOW  = 12'(IDX_CNT_LOW * 4);
  localparam logic [11:0] ADDR_CTRL     = 12'h010;
  localparam logic [11:0] ADDR_PC_FULL  = 12'h014;
  localparam logic [11:0] ADDR_STATUS   = 12'h01C;
  localparam logic [10:0] VEC_RESET     = 11'h000;
  localparam logic [10:0] VEC_EXT_INT   = 11'h004;
  localparam logic [10:0] VEC_TMR_INT   = 11'h008;
  localparam logic [1:0]  PHASE_RST     = 2'h0;
  localparam logic [1:0]  PHASE_LAST    = 2'h3;
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam logic [31:0] CTRL_RST_VAL  = 32'h0000_0001;

  // ****************************************
  // Types
  // ****************************************
  // Transfer request from the decoder
  typedef enum logic [2:0]
  {
    PCS_XFER_NONE  = 3'h0,
    PCS_XFER_JUMP  = 3'h1,
    PCS_XFER_RET   = 3'h2,
    PCS_XFER_SKIP  = 3'h3,
    PCS_XFER_EXT   = 3'h4,
    PCS_XFER_TMR   = 3'h5
  } pcs_xfer_t;

  typedef struct packed
  {
    pcs_xfer_t   kind;
    logic [10:0] target;
  } pcs_req_t;

  typedef enum logic [1:0]
  {
    PCS_ST_EXEC  = 2'b00,
    PCS_ST_DUMMY = 2'b01
  } pcs_state_t;

endpackage
`default_nettype wire

// ### design/pcs_phase_gen.sv
`default_nettype none
// ****************************************
// Four-phase divider of the system clock
// ****************************************
module pcs_phase_gen #(
  parameter int unsigned N = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  // Phase outputs
  output logic [N-1:0]      phase,
  output logic              cycle_end
);

  logic [1:0] cnt_r;

  // Phase counter, one instruction cycle per wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= pcs_pkg::PHASE_RST;
    else if (clk_en)
      cnt_r <= cnt_r + 2'h1;
  end

  // One-hot non-overlapping phases
  always_comb
  begin
    phase        = '0;
    phase[cnt_r] = 1'b1;
  end

  assign cycle_end = clk_en && (cnt_r == pcs_pkg::PHASE_LAST);

endmodule
`default_nettype wire

// ### design/pcs_sequencer.sv
// The APB register port is this design's own decision.
`default_nettype none
module pcs_sequencer (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Decoder transfer request, sampled at cycle end
  input  wire pcs_pkg::pcs_req_t    xfer_req,
  input  wire logic [10:0]          stack_top,
  // Program memory and decoder
  output logic [10:0]               fetch_addr,
  output logic                      fetch_strobe,
  output logic                      exec_valid,
  output logic [3:0]                phase,
  output logic                      xfer_ack
);

  // ****************************************
  // Phase generation
  // ****************************************
  logic       cycle_end;
  logic       run;
  logic       adv;
  logic [31:0] ctrl_r;

  pcs_phase_gen #(.N(pcs_pkg::PHASES)) u_phase (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // Clearing run halts the counter at a cycle boundary while the phases
  // keep turning, so a restart always lines up with phase zero
  assign run = ctrl_r[pcs_pkg::CTRL_RUN_BIT];
  assign adv = cycle_end && run;

  // ****************************************
  // APB decode
  // ****************************************
  logic apb_wr;
  logic hit_low;
  logic hit_ctrl;
  logic hit_any;

  // No wait states while clocked; a frozen block stalls the bus
  // so that no write is acknowledged and then lost
  assign pready   = clk_en;
  assign apb_wr   = clk_en && psel && penable && pwrite;
  assign hit_low  = (paddr == pcs_pkg::ADDR_CNT_LOW);
  assign hit_ctrl = (paddr == pcs_pkg::ADDR_CTRL);
  assign hit_any  = hit_low || hit_ctrl || (paddr == pcs_pkg::ADDR_PC_FULL)
                    || (paddr == pcs_pkg::ADDR_STATUS);
  // Unmapped addresses answer with an error, no state change
  assign pslverr = psel && penable && !hit_any;

  // ****************************************
  // Control register
  // ****************************************
  // Run bit gates sequencing; only bit 0 is kept, the rest reads zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= pcs_pkg::CTRL_RST_VAL;
    else if (apb_wr && hit_ctrl)
      ctrl_r <= {31'h0, pwdata[0]};
  end

  // ****************************************
  // Sequencing state
  // ****************************************
  pcs_pkg::pcs_state_t state_r;
  pcs_pkg::pcs_state_t state_nxt;
  logic [10:0]         pc_r;
  logic [10:0]         pc_nxt;
  logic                low_pend_r;
  logic [7:0]          low_val_r;
  logic                xfer;

  // A low-byte write is held until the next boundary that ends an executing cycle so the
  // reload aligns with the pipeline rather than tearing a fetch.
  // A new write in the boundary clock wins: the old byte is applied
  // and the new one stays pending for the next executing cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_pend_r <= 1'b0;
      low_val_r  <= 8'h00;
    end
    else if (apb_wr && hit_low)
    begin
      low_pend_r <= 1'b1;
      low_val_r  <= pwdata[7:0];
    end
    else if (adv && state_r == pcs_pkg::PCS_ST_EXEC)
      low_pend_r <= 1'b0;
  end

  // Next counter value and transfer decision
  // A dummy cycle only steps on; requests wait for a cycle that executes
  always_comb
  begin
    pc_nxt    = pc_r + 11'h001;
    xfer      = 1'b1;
    state_nxt = pcs_pkg::PCS_ST_EXEC;
    if (state_r == pcs_pkg::PCS_ST_DUMMY)
    begin
      xfer = 1'b0;  // Dummy cycle: fetch at new target, nothing executes
    end
    else if (low_pend_r)
      pc_nxt = {pc_r[10:8], low_val_r};  // outranks a held decoder request
    else
    begin
      unique case (xfer_req.kind)
        pcs_pkg::PCS_XFER_JUMP: pc_nxt = xfer_req.target;
        pcs_pkg::PCS_XFER_RET:  pc_nxt = stack_top;
        pcs_pkg::PCS_XFER_SKIP: pc_nxt = pc_r + 11'h001;
        pcs_pkg::PCS_XFER_EXT:  pc_nxt = pcs_pkg::VEC_EXT_INT;
        pcs_pkg::PCS_XFER_TMR:  pc_nxt = pcs_pkg::VEC_TMR_INT;
        pcs_pkg::PCS_XFER_NONE: xfer = 1'b0;
        default:                xfer = 1'b0;
      endcase
    end
    if (xfer)
      state_nxt = pcs_pkg::PCS_ST_DUMMY;
  end

  // Program counter and pipeline state
  // Both move only at a cycle boundary with run set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_r    <= pcs_pkg::VEC_RESET;
      state_r <= pcs_pkg::PCS_ST_DUMMY;  // First word is fetched before anything runs
    end
    else if (adv)
    begin
      pc_r    <= pc_nxt;
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Fetch side
  // ****************************************
  // Fetch address registered; execute valid once the pipe holds a real word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_addr <= pcs_pkg::VEC_RESET;
      exec_valid <= 1'b0;
    end
    else if (adv)
    begin
      fetch_addr <= pc_nxt;
      exec_valid <= (state_nxt == pcs_pkg::PCS_ST_EXEC);
    end
  end

  // Strobe is combinational so memory sees it in the boundary clock itself
  assign fetch_strobe = adv;

  // Acknowledge in the clock after the decoder's request was taken; a held
  // low-byte write refuses the request, which the decoder then keeps up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xfer_ack <= 1'b0;
    else if (clk_en)
      xfer_ack <= adv && xfer && !low_pend_r;
  end

  // ****************************************
  // Register read
  // ****************************************
  // Read data straight from state, valid through the access phase;
  // unmapped addresses read zero
  always_comb
  begin
    prdata = 32'h0;
    if (psel && !pwrite)
    begin
      if (hit_low)
        prdata = {24'h0, pc_r[7:0]};
      else if (hit_ctrl)
        prdata = ctrl_r;
      else if (paddr == pcs_pkg::ADDR_PC_FULL)
        prdata = {21'h0, pc_r};
      else if (paddr == pcs_pkg::ADDR_STATUS)
        prdata = {28'h0, low_pend_r, exec_valid, state_r};
    end
  end

endmodule
`default_nettype wire

// ### test/pcs_monitor.sv
`default_nettype none
// ******
// Sequencer port checker
// ******
module pcs_monitor (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  // Sequencer side
  input wire pcs_pkg::pcs_req_t xfer_req,
  input wire logic [10:0]       fetch_addr,
  input wire logic              fetch_strobe,
  input wire logic              exec_valid,
  input wire logic [3:0]        phase,
  input wire logic              xfer_ack
);
  // One domain, so clock and reset are shared
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_phase_hot: assert property ($onehot(phase))
    else $error("phase not one-hot");
  chk_phase_wrap: assert property (clk_en && phase[3] |=> phase[0])
    else $error("phase did not wrap");
  chk_fetch_hold: assert property (clk_en && !phase[3] |=> $stable(fetch_addr))
    else $error("fetch address moved mid-cycle");
  chk_dummy_after: assert property (xfer_ack |-> !exec_valid)
    else $error("no dummy after transfer");
  chk_dummy_len: assert property ($fell(exec_valid) |-> (!exec_valid)[*4])
    else $error("dummy cycle too short");
  chk_ack_pulse: assert property (clk_en && xfer_ack |=> !xfer_ack)
    else $error("ack longer than one clock");
  chk_strobe_phase: assert property (fetch_strobe |-> phase[3] && clk_en)
    else $error("fetch strobe off the last phase");
  chk_fetch_moves: assert property ($changed(fetch_addr) |-> $past(fetch_strobe))
    else $error("fetch address moved without a strobe");
  // Tests assume no low-byte write is pending alongside
  chk_ext_vec: assert property (clk_en && phase[3] && exec_valid && xfer_req.kind == pcs_pkg::PCS_XFER_EXT
    |=> fetch_addr == pcs_pkg::VEC_EXT_INT)
    else $error("external vector wrong");
  chk_tmr_vec: assert property (clk_en && phase[3] && exec_valid && xfer_req.kind == pcs_pkg::PCS_XFER_TMR
    |=> fetch_addr == pcs_pkg::VEC_TMR_INT)
    else $error("timer vector wrong");
endmodule
bind pcs_sequencer pcs_monitor u_pcs_monitor (.pclk, .presetn, .clk_en, .xfer_req, .fetch_addr, .fetch_strobe,
  .exec_valid, .phase, .xfer_ack);
`default_nettype wire

// ### test/pcs_decoder_model.sv
`default_nettype none
// ******
// Decoder stand-in
// ******
module pcs_decoder_model #(
  parameter logic [10:0] RET_ADDR = 11'h3A5
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Bench command
  input  wire logic              go,
  input  wire pcs_pkg::pcs_req_t cmd,
  // Sequencer side
  input  wire logic              xfer_ack,
  output pcs_pkg::pcs_req_t      xfer_req,
  output logic [10:0]            stack_top
);
  // Level held until taken, so a slow answer is never lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xfer_req <= '0;
    else if (xfer_ack)
      xfer_req <= '0;
    else if (go)
      xfer_req <= cmd;
  end
  // Fixed value stands in for the stack
  assign stack_top = RET_ADDR;
endmodule
`default_nettype wire

// ### test/tb_top.sv
`default_nettype none
// ******
// Sequencer bench
// ******
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] RET = 11'h3A5;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, go = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic fetch_strobe, exec_valid, xfer_ack;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] fetch_addr, stack_top, base;
  logic [3:0] phase;
  pcs_pkg::pcs_req_t cmd = '0, xfer_req;
  pcs_pkg::pcs_xfer_t ks[5] = '{pcs_pkg::PCS_XFER_EXT, pcs_pkg::PCS_XFER_TMR, pcs_pkg::PCS_XFER_RET,
    pcs_pkg::PCS_XFER_JUMP, pcs_pkg::PCS_XFER_SKIP};
  logic [10:0] xs[5] = '{pcs_pkg::VEC_EXT_INT, pcs_pkg::VEC_TMR_INT, RET, 11'h512, 11'h512};
  int err_total = 0, samples_checked = 0, cycles = 0;
  always #10 pclk = ~pclk;
  pcs_sequencer u_pcs_sequencer (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .xfer_req, .stack_top, .fetch_addr, .fetch_strobe, .exec_valid, .phase,
    .xfer_ack);
  pcs_decoder_model #(.RET_ADDR(RET)) u_pcs_decoder_model (.pclk, .presetn, .go, .cmd, .xfer_ack,
    .xfer_req, .stack_top);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Returns just after the edge ending an instruction cycle
  task cyc;
    do @(posedge pclk); while (phase[3] !== 1'b1);
    #1;
  endtask
  // Request lands in a normal cycle, checked at its end
  task xfer(input pcs_pkg::pcs_xfer_t k, input logic [10:0] t);
    cyc;
    base = fetch_addr;
    cmd <= '{k, t};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    cyc;
    chk(fetch_addr, (k == pcs_pkg::PCS_XFER_SKIP) ? base + 11'h001 : t);
    chk(exec_valid, 1'b0);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far above the hundred or so clocks needed
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk(fetch_addr, 11'h000);
    cyc;
    base = fetch_addr;
    cyc;
    chk(fetch_addr, base + 11'h001);
    $display("test sequence done");
    for (int i = 0; i < 5; i++)
      xfer(ks[i], xs[i]);
    $display("test transfers done");
    cyc;
    apb(1'b1, pcs_pkg::ADDR_CNT_LOW, 32'h0000_003C);
    chk(er, 1'b0);
    cyc;
    chk(fetch_addr, 11'h53C);
    apb(1'b0, pcs_pkg::ADDR_CNT_LOW, 32'h0);
    chk(rd, 32'h0000_003C);
    apb(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    $display("test low byte done");
    xfer(pcs_pkg::PCS_XFER_JUMP, 11'h7FF);
    cyc;
    chk(fetch_addr, 11'h000);
    $display("test wrap done");
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (8) @(posedge pclk);
    #1;
    chk(phase, 4'h2);
    chk(fetch_addr, 11'h000);
    @(posedge pclk);
    clk_en <= 1'b1;
    cyc;
    chk(fetch_addr, 11'h001);
    $display("test freeze done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
